// >>> hw/csd_pkg.sv
package csd_pkg;
   // ----------------------------------------------------------------
   // Register map (APB byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_PAGE = 8'h08;
   localparam logic [7:0] ADDR_OPER = 8'h0C;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_RESHI = 8'h14;
   localparam logic [7:0] ADDR_REGSEL = 8'h18;
   localparam logic [7:0] ADDR_REGDATA = 8'h1C;
   localparam logic [7:0] ADDR_DADDR = 8'h20;
   localparam logic [7:0] ADDR_WINADDR = 8'h24;
   localparam logic [7:0] ADDR_PC = 8'h28;
   localparam logic [7:0] ADDR_FETCH = 8'h2C;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_OV = 2;
   localparam int SR_N = 3;
   localparam int SR_RA = 4;
   localparam int SR_IPL_LO = 5;
   localparam int SR_IPL_HI = 7;
   localparam int SR_DC = 8;
   localparam int CC_PSV = 2;
   localparam int CC_PRIORITY_LEVEL_TOP = 3;
   localparam logic [15:0] SR_WMASK = 16'h01EF;
   localparam logic [15:0] SR_RESET = 16'h0000;
   localparam logic [15:0] CC_RESET = 16'h0000;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [22:0] PC_RESET = 23'h000000;
   localparam int DIV_CYCLES = 19;
   localparam logic [4:0] DIV_LAST = 5'h12;
   // ----------------------------------------------------------------
   // Operation codes written to the operation register bits 3:0
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_ADD = 4'b0000,
      OP_SUB = 4'b0001,
      OP_MULUU = 4'b0010,
      OP_MULSS = 4'b0011,
      OP_MULSU = 4'b0100,
      OP_SHL = 4'b0101,
      OP_SHR = 4'b0110,
      OP_DIVU = 4'b0111,
      OP_DIVL = 4'b1000,
      OP_ADDB = 4'b1001,
      OP_MOVD = 4'b1010,
      OP_BRA = 4'b1011,
      OP_TBL = 4'b1100,
      OP_NOP = 4'b1101,
      OP_RES0 = 4'b1110,
      OP_RES1 = 4'b1111
   } csd_op_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV = 2'b01,
      ST_MULTI = 2'b10
   } csd_state_type;
endpackage : csd_pkg

// >>> hw/csd_core.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module csd_core
   import csd_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic NESTING_DISABLE,
   input wire logic INTERRUPT_REQ,
   output logic [3:0] PRIORITY_LEVEL,
   output logic USER_INT_BLOCKED,
   output logic LOOP_BUSY,
   output logic [22:0] PROGRAM_COUNTER
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0] status_reg;
   logic [15:0] control_reg;
   logic [7:0] page_reg;
   logic [15:0] work_reg [16];
   logic [3:0] regsel_reg;
   logic [15:0] opa_reg;
   logic [15:0] opb_reg;
   logic [15:0] res_reg;
   logic [15:0] reshi_reg;
   logic [15:0] daddr_reg;
   logic [22:0] pc_reg;
   logic [23:0] fetch_reg;
   logic [31:0] rem_reg;
   logic [15:0] quot_reg;
   logic [4:0] cnt_reg;
   logic [1:0] wait_reg;
   csd_state_type state_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [3:0] prio_reg;
   logic blocked_reg;
   logic busy_reg;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic setup = PSEL && !PENABLE;
   // Writes land in the access cycle, at the edge that sees the ready.
   wire logic access = PSEL && PENABLE && pready_reg;
   wire logic wr = access && PWRITE;
   wire logic hit = PADDR <= ADDR_FETCH && PADDR[1:0] == 2'b00;
   wire logic wr_sr = wr && PADDR == ADDR_STATUS;
   wire logic wr_cc = wr && PADDR == ADDR_CONTROL;
   wire logic wr_pg = wr && PADDR == ADDR_PAGE;
   wire logic wr_op = wr && PADDR == ADDR_OPER;
   wire logic wr_sel = wr && PADDR == ADDR_REGSEL;
   wire logic wr_reg = wr && PADDR == ADDR_REGDATA;
   wire logic wr_da = wr && PADDR == ADDR_DADDR;
   wire logic wr_pc = wr && PADDR == ADDR_PC;
   wire logic idle = state_reg == ST_IDLE;

   // ----------------------------------------------------------------
   // Operation decode
   // ----------------------------------------------------------------
   wire csd_op_type op = csd_op_type'(PWDATA[3:0]);
   wire logic [3:0] rs_a = PWDATA[7:4];
   wire logic [3:0] rs_b = PWDATA[11:8];
   wire logic [3:0] rd = PWDATA[15:12];
   wire logic [4:0] shamt = PWDATA[20:16];
   // Both source registers and the destination are used in one cycle.
   wire logic [15:0] a = work_reg[rs_a];
   wire logic [15:0] b = work_reg[rs_b];
   wire logic start = wr_op && idle;

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   wire logic is_sub = op == OP_SUB;
   wire logic [15:0] b_eff = is_sub ? ~b : b;
   wire logic [16:0] sum = {1'b0, a} + {1'b0, b_eff} + {16'h0000, is_sub};
   wire logic [8:0] low8 = {1'b0, a[7:0]} + {1'b0, b_eff[7:0]}
      + {8'h00, is_sub};
   wire logic [8:0] bsum = {1'b0, a[7:0]} + {1'b0, b[7:0]};
   wire logic [4:0] low4 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
   wire logic ovw = (a[15] == b_eff[15]) && (sum[15] != a[15]);
   wire logic ovb = (a[7] == b[7]) && (bsum[7] != a[7]);
   // Signed 17-bit operands cover the unsigned, signed and signed-by-unsigned cases.
   wire logic sa = (op == OP_MULSS || op == OP_MULSU) && a[15];
   wire logic sb = op == OP_MULSS && b[15];
   wire logic signed [33:0] prod = $signed({sa, a}) * $signed({sb, b});
   wire logic [31:0] shl = {16'h0000, a} << shamt;
   wire logic [31:0] shr = {a, 16'h0000} >> shamt;

   // ----------------------------------------------------------------
   // Restoring divider step
   // ----------------------------------------------------------------
   // The partial remainder stays below the divisor, so it lives in the low
   // half of rem_reg and one extra trial bit catches the borrow.
   wire logic [16:0] trial = {rem_reg[15:0], quot_reg[15]} - {1'b0, opb_reg};
   wire logic [15:0] quot_step = trial[16] ? {quot_reg[14:0], 1'b0}
      : {quot_reg[14:0], 1'b1};
   wire logic [31:0] rem_step = trial[16]
      ? {16'h0000, rem_reg[14:0], quot_reg[15]} : {16'h0000, trial[15:0]};

   // ----------------------------------------------------------------
   // Program window address
   // ----------------------------------------------------------------
   wire logic win_on = control_reg[CC_PSV];
   wire logic [22:0] win_addr = {page_reg, daddr_reg[14:0]};
   wire logic [31:0] win_rd = (win_on && daddr_reg[15])
      ? {9'h000, win_addr} : {16'h0000, daddr_reg};

   // ----------------------------------------------------------------
   // Status next value
   // ----------------------------------------------------------------
   wire logic [15:0] sr_wr = (status_reg & ~SR_WMASK) | (PWDATA[15:0] & SR_WMASK)
      ;
   wire logic [15:0] sr_lock = NESTING_DISABLE
      ? {sr_wr[15:8], status_reg[7:5], sr_wr[4:0]} : sr_wr;
   logic [15:0] status_next;
   logic [15:0] res_next;
   always_comb
   begin
      status_next = wr_sr ? sr_lock : status_reg;
      res_next = res_reg;
      if (start)
      begin
         unique case (op)
            OP_ADD, OP_SUB:
            begin
               res_next = sum[15:0];
               status_next[SR_C] = sum[16];
               status_next[SR_DC] = low8[8];
               status_next[SR_N] = sum[15];
               status_next[SR_OV] = ovw;
               if (sum[15:0] != 16'h0000)
                  status_next[SR_Z] = 1'b0;
               else
                  status_next[SR_Z] = 1'b1;
            end
            OP_ADDB:
            begin
               res_next = {a[15:8], bsum[7:0]};
               status_next[SR_C] = bsum[8];
               status_next[SR_DC] = low4[4];
               status_next[SR_N] = bsum[7];
               status_next[SR_OV] = ovb;
               status_next[SR_Z] = bsum[7:0] == 8'h00;
            end
            OP_MULUU, OP_MULSS, OP_MULSU: res_next = prod[15:0];
            OP_SHL: res_next = shl[15:0];
            OP_SHR: res_next = shr[31:16];
            default: res_next = res_reg;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Datapath and sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         status_reg <= SR_RESET;
         control_reg <= CC_RESET;
         page_reg <= PAGE_RESET;
         regsel_reg <= 4'h0;
         opa_reg <= 16'h0000;
         opb_reg <= 16'h0000;
         res_reg <= 16'h0000;
         reshi_reg <= 16'h0000;
         daddr_reg <= 16'h0000;
         pc_reg <= PC_RESET;
         fetch_reg <= 24'h000000;
         rem_reg <= 32'h00000000;
         quot_reg <= 16'h0000;
         cnt_reg <= 5'h00;
         wait_reg <= 2'h0;
         state_reg <= ST_IDLE;
      end
      else
      begin
         status_reg <= status_next;
         res_reg <= res_next;
         if (wr_cc)
         begin
            control_reg[CC_PSV] <= PWDATA[CC_PSV];
            // Software may drop the top priority bit but never raise it.
            if (!PWDATA[CC_PRIORITY_LEVEL_TOP])
               control_reg[CC_PRIORITY_LEVEL_TOP] <= 1'b0;
         end
         if (wr_pg)
            page_reg <= PWDATA[7:0];
         if (wr_sel)
            regsel_reg <= PWDATA[3:0];
         if (wr_da)
            daddr_reg <= PWDATA[15:0];
         if (wr_pc)
            pc_reg <= PWDATA[22:0];
         // Next word is fetched each idle cycle, ahead of execution.
         if (idle)
            fetch_reg <= {1'b0, pc_reg};
         if (start)
         begin
            pc_reg <= pc_reg + 23'h000001;
            unique case (op)
               OP_MULUU, OP_MULSS, OP_MULSU:
                  reshi_reg <= prod[31:16];
               OP_SHL: reshi_reg <= shl[31:16];
               OP_DIVU, OP_DIVL:
               begin
                  // Divide runs as an interruptible loop; state lives
                  // in registers so an interrupt loses nothing.
                  opb_reg <= b;
                  opa_reg <= a;
                  rem_reg <= op == OP_DIVL ? {16'h0000, res_reg} : 32'h0;
                  quot_reg <= a;
                  cnt_reg <= 5'h00;
                  status_reg[SR_RA] <= 1'b1;
                  state_reg <= ST_DIV;
               end
               OP_MOVD, OP_BRA, OP_TBL:
               begin
                  wait_reg <= 2'h1;
                  state_reg <= ST_MULTI;
               end
               default: reshi_reg <= reshi_reg;
            endcase
         end
         unique case (state_reg)
            ST_IDLE: cnt_reg <= cnt_reg;
            ST_DIV:
            begin
               // A pending interrupt stretches, but never corrupts, it.
               if (!INTERRUPT_REQ)
               begin
                  if (cnt_reg < 5'h10)
                  begin
                     quot_reg <= quot_step;
                     rem_reg <= rem_step;
                  end
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == DIV_LAST)
                  begin
                     res_reg <= quot_reg;
                     reshi_reg <= rem_reg[15:0];
                     status_reg[SR_RA] <= 1'b0;
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_MULTI:
            begin
               if (wait_reg == 2'h0)
                  state_reg <= ST_IDLE;
               else
                  wait_reg <= wait_reg - 2'h1;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Working registers: one write port, index 15 is the stack pointer.
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < 16; i++)
            work_reg[i] <= 16'h0000;
      end
      else if (wr_reg)
         work_reg[regsel_reg] <= PWDATA[15:0];
      else if (start && op != OP_NOP && op != OP_BRA)
         work_reg[rd] <= res_next;
   end

   // ----------------------------------------------------------------
   // Read mux and outputs
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (PADDR)
         ADDR_STATUS: rd_mux = {16'h0000, status_reg & 16'h01FF};
         ADDR_CONTROL: rd_mux = {16'h0000, control_reg & 16'h000C};
         ADDR_PAGE: rd_mux = {24'h000000, page_reg};
         ADDR_OPER: rd_mux = {30'h0, state_reg};
         ADDR_RESULT: rd_mux = {16'h0000, res_reg};
         ADDR_RESHI: rd_mux = {16'h0000, reshi_reg};
         ADDR_REGSEL: rd_mux = {28'h0000000, regsel_reg};
         ADDR_REGDATA: rd_mux = {16'h0000, work_reg[regsel_reg]};
         ADDR_DADDR: rd_mux = {16'h0000, daddr_reg};
         ADDR_WINADDR: rd_mux = win_rd;
         ADDR_PC: rd_mux = {9'h000, pc_reg};
         ADDR_FETCH: rd_mux = {8'h00, fetch_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prio_reg <= 4'h0;
         blocked_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= setup;
         pslverr_reg <= setup && !hit;
         prdata_reg <= setup && !PWRITE ? rd_mux : 32'h00000000;
         prio_reg <= {control_reg[CC_PRIORITY_LEVEL_TOP], status_reg[SR_IPL_HI:SR_IPL_LO]}
            ;
         blocked_reg <= control_reg[CC_PRIORITY_LEVEL_TOP]
            || status_reg[SR_IPL_HI:SR_IPL_LO] == 3'b111;
         busy_reg <= status_reg[SR_RA];
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign PRIORITY_LEVEL = prio_reg;
   assign USER_INT_BLOCKED = blocked_reg;
   assign LOOP_BUSY = busy_reg;
   assign PROGRAM_COUNTER = pc_reg;
endmodule : csd_core

// >>> dv/csd_core_chk.sv
`timescale 1ns/1ps
module csd_core_chk
   import csd_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic NESTING_DISABLE,
   input wire logic INTERRUPT_REQ,
   input wire logic [3:0] PRIORITY_LEVEL,
   input wire logic USER_INT_BLOCKED,
   input wire logic LOOP_BUSY,
   input wire logic [22:0] PROGRAM_COUNTER
);
   // ----------------------------------------------------------------
   // Status and control checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SYS_RST);
   wire rd_acc = PREADY && !PWRITE;
   wire st_set = PSEL && PENABLE && PREADY && PWRITE
      && PADDR == ADDR_STATUS;
   AST_STATUS_ZERO: assert property (rd_acc && PADDR == ADDR_STATUS
      |-> PRDATA[31:9] == 23'h0) else $error("status upper bits set");
   AST_CONTROL_ZERO: assert property (rd_acc && PADDR == ADDR_CONTROL
      |-> PRDATA[31:4] == 28'h0 && PRDATA[1:0] == 2'h0)
      else $error("control unused bits set");
   AST_TOP_CLEAR_ONLY: assert property (!$rose(PRIORITY_LEVEL[3]))
      else $error("priority top bit was set");
   AST_BLOCKED: assert property (USER_INT_BLOCKED ==
      (PRIORITY_LEVEL[3] || PRIORITY_LEVEL[2:0] == 3'h7))
      else $error("user interrupt block wrong");
   AST_NEST_HOLD: assert property (st_set && NESTING_DISABLE
      |=> $stable(PRIORITY_LEVEL[2:0]) [*2]) else $error("priority moved");
   AST_LOOP_MIN: assert property ($rose(LOOP_BUSY) |-> LOOP_BUSY [*8])
      else $error("divide loop too short");
   AST_LOOP_WRITE: assert property (st_set && !LOOP_BUSY
      |=> ##1 !LOOP_BUSY) else $error("status write set loop flag");
   AST_PRIO_READ: assert property (rd_acc && PADDR == ADDR_STATUS
      |-> PRDATA[7:5] == PRIORITY_LEVEL[2:0]) else $error("priority read");
   COV_ERR: cover property (PSLVERR);
   COV_DIV: cover property ($rose(LOOP_BUSY));
   COV_NEST: cover property (st_set && NESTING_DISABLE);
endmodule : csd_core_chk
bind csd_core csd_core_chk chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .NESTING_DISABLE(NESTING_DISABLE), .INTERRUPT_REQ(INTERRUPT_REQ),
   .PRIORITY_LEVEL(PRIORITY_LEVEL), .USER_INT_BLOCKED(USER_INT_BLOCKED),
   .LOOP_BUSY(LOOP_BUSY), .PROGRAM_COUNTER(PROGRAM_COUNTER));

// >>> dv/csd_core_test.sv
`timescale 1ns/1ps
module csd_core_test
   import csd_pkg::*;
();
   logic CLOCK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
   logic PWRITE = 1'b0, NESTING_DISABLE = 1'b0, INTERRUPT_REQ = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h00000000;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, USER_INT_BLOCKED, LOOP_BUSY;
   logic [3:0] PRIORITY_LEVEL;
   logic [22:0] PROGRAM_COUNTER;
   logic [31:0] seed = 32'h00014747;
   logic [32:0] exp_q[$];
   int err_total = 0;
   int checked = 0;
   always #12.5 CLOCK = ~CLOCK;
   csd_core uut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .NESTING_DISABLE(NESTING_DISABLE), .INTERRUPT_REQ(INTERRUPT_REQ),
      .PRIORITY_LEVEL(PRIORITY_LEVEL), .USER_INT_BLOCKED(USER_INT_BLOCKED),
      .LOOP_BUSY(LOOP_BUSY), .PROGRAM_COUNTER(PROGRAM_COUNTER));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task check(input string nm, input logic [32:0] seen, logic [32:0] ex);
      checked++;
      if (seen !== ex)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check
   task stop_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // The expected answer is queued first; the monitor pairs it by order.
   task apb(input logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 50);
      if (PREADY !== 1'b1)
         err_total++;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask : rd
   task alu(input logic [3:0] op, logic [15:0] x, y, logic [4:0] sh);
      wr(ADDR_REGSEL, 32'h1);
      wr(ADDR_REGDATA, {16'h0, x});
      wr(ADDR_REGSEL, 32'h2);
      wr(ADDR_REGDATA, {16'h0, y});
      wr(ADDR_OPER, {11'h0, sh, 12'h321, op});
   endtask : alu
   always @(posedge CLOCK)
      if (PREADY === 1'b1)
         check("apb", {PSLVERR, PRDATA}, exp_q.pop_front());
   initial
   begin
      #200000;
      err_total++;
      stop_test();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [15:0] a, b;
      logic [16:0] s;
      logic [8:0] h;
      logic [31:0] p;
      logic ov;
      int k;
      repeat (16) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      rd(ADDR_STATUS, 32'h0);
      rd(ADDR_CONTROL, 32'h0);
      rd(ADDR_PAGE, 32'h0);
      rd(ADDR_PC, 32'h0);
      wr(ADDR_STATUS, 32'hFFFFFFFF);
      rd(ADDR_STATUS, 32'h000001EF);
      check("level", 33'(PRIORITY_LEVEL), 33'h7);
      check("blocked", 33'(USER_INT_BLOCKED), 33'h1);
      NESTING_DISABLE <= 1'b1;
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS, 32'h000000E0);
      NESTING_DISABLE <= 1'b0;
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      check("unblocked", 33'(USER_INT_BLOCKED), 33'h0);
      wr(ADDR_CONTROL, 32'hFFFFFFFF);
      rd(ADDR_CONTROL, 32'h4);
      apb(1'b0, 8'h40, 32'h0, 33'h100000000);
      apb(1'b1, 8'h41, 32'h1, 33'h100000000);
      wr(ADDR_PAGE, 32'hA5);
      wr(ADDR_DADDR, 32'h9234);
      rd(ADDR_WINADDR, {9'h0, 8'hA5, 15'h1234});
      wr(ADDR_CONTROL, 32'h0);
      rd(ADDR_WINADDR, 32'h9234);
      for (k = 0; k < 12; k++)
      begin
         p = rnd();
         a = p[15:0];
         b = (k == 1) ? a : p[31:16];
         alu(k[0] ? OP_SUB : OP_ADD, a, b, 5'h0);
         s = {1'b0, a} + {1'b0, k[0] ? ~b : b} + {16'h0, k[0]};
         h = {1'b0, a[7:0]} + {1'b0, k[0] ? ~b[7:0] : b[7:0]} + {8'h0, k[0]};
         ov = ((a[15] ^ b[15]) == k[0]) && (s[15] != a[15]);
         rd(ADDR_RESULT, {16'h0, s[15:0]});
         rd(ADDR_STATUS, {23'h0, h[8], 4'h0, s[15], ov,
            s[15:0] == 16'h0, s[16]});
      end
      for (k = 0; k < 3; k++)
      begin
         p = rnd();
         a = p[15:0] | 16'h8000;
         b = p[31:16] | 16'h8000;
         alu(4'(k + 2), a, b, 5'h0);
         p = {16'h0, a} * {16'h0, b};
         if (k == 1) p = $signed(a) * $signed(b);
         if (k == 2) p = $signed(a) * $signed({1'b0, b});
         rd(ADDR_RESULT, {16'h0, p[15:0]});
         rd(ADDR_RESHI, {16'h0, p[31:16]});
      end
      alu(OP_SHL, a, b, 5'h10);
      rd(ADDR_RESULT, 32'h0);
      alu(OP_SHR, a & 16'h7FFF, b, 5'h4);
      rd(ADDR_RESULT, {16'h0, (a & 16'h7FFF) >> 4});
      b = p[15:0] | 16'h0001;
      alu(OP_DIVU, a, b, 5'h0);
      repeat (4) @(posedge CLOCK);
      check("busy", 33'(LOOP_BUSY), 33'h1);
      INTERRUPT_REQ <= 1'b1;
      repeat (5) @(posedge CLOCK);
      INTERRUPT_REQ <= 1'b0;
      k = 0;
      while (LOOP_BUSY === 1'b1 && k < 100)
      begin
         @(posedge CLOCK);
         k++;
      end
      if (k == 100)
         err_total++;
      rd(ADDR_RESULT, {16'h0, a / b});
      rd(ADDR_RESHI, {16'h0, a % b});
      wr(ADDR_OPER, {28'h0, OP_BRA});
      rd(ADDR_OPER, {30'h0, ST_MULTI});
      rd(ADDR_OPER, 32'h0);
      rd(ADDR_PC, 32'h13);
      check("pc", 33'(PROGRAM_COUNTER), 33'h13);
      @(posedge CLOCK);
      check("pending", 33'(exp_q.size()), 33'h0);
      stop_test();
   end
endmodule : csd_core_test
